// [dpoc_output_ctrl.sv]
// Purpose: receive-side parallel output port control with register access
// Assumes: recovered clock and word are sampled by the core clock (8+ cycles a period)
// Notes:   one core cycle stands in for one unit interval of the serial link
//
// Strobed register access and the register addresses are this design's own decisions.
`include "dpoc_params.svh"
`default_nettype none

module dpoc_output_ctrl (
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  // recovered link side
  input  wire logic        link_clk_in,
  input  wire logic [23:0] rx_word_in,
  input  wire logic        pll_locked_in,
  // configuration pins
  input  wire logic        output_edge_select_in,
  input  wire logic        output_enable_in,
  input  wire logic        receiver_sleep_n_in,
  input  wire logic        staggered_turnon_select_in,
  input  wire logic        randomizer_disable_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  output logic             irq_out,
  // parallel output pins
  output logic      [23:0] parallel_data_out,
  output logic      [2:0]  parallel_data_oe_out,
  output logic             out_clk_out,
  output logic             out_clk_oe_out,
  output logic             lock_out,
  output logic             lock_oe_out,
  output logic             pll_enable_out
);

  dpoc_pkg::dpoc_pins_t pins_raw;
  dpoc_pkg::dpoc_pins_t pins_s;
  dpoc_pkg::dpoc_word_t word_s;
  logic                 link_s;
  logic [30:0]          sync_bus;

  // gather every outside level into one synchroniser
  assign pins_raw.edge_sel    = output_edge_select_in;
  assign pins_raw.out_en      = output_enable_in;
  assign pins_raw.sleep_n     = receiver_sleep_n_in;
  assign pins_raw.stagger_sel = staggered_turnon_select_in;
  assign pins_raw.rand_dis    = randomizer_disable_in;
  assign pins_raw.pll_locked  = pll_locked_in;

  dpoc_sync #(
    .WIDTH (31)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .async_in    ({rx_word_in, link_clk_in, pins_raw}),
    .sync_out    (sync_bus)
  );

  // word and clock share the same delay, so the word is settled at the clock edge
  assign pins_s = dpoc_pkg::dpoc_pins_t'(sync_bus[5:0]);
  assign link_s = sync_bus[6];
  assign word_s = sync_bus[30:7];

  logic                 link_prev_reg;
  logic                 locked_prev_reg;
  logic [6:0]           lfsr_reg;
  logic [6:0]           lfsr_next;
  dpoc_pkg::dpoc_word_t word_reg;
  dpoc_pkg::dpoc_word_t word_next;
  logic [1:0]           launch_reg;
  logic                 clk_dly_reg;
  logic [23:0]          data_reg;
  logic [2:0]           data_oe_reg;
  logic                 clk_reg;
  logic                 clk_oe_reg;
  logic                 lock_reg;
  logic                 lock_oe_reg;
  logic                 pll_en_reg;
  logic [`DPOC_EV_W-1:0] status_reg;
  logic [`DPOC_EV_W-1:0] status_next;
  logic [`DPOC_EV_W-1:0] mask_reg;
  logic                 irq_reg;
  logic [31:0]          rdata_reg;

  // edges of the sampled recovered clock
  wire link_rise = link_s & ~link_prev_reg;
  wire link_fall = ~link_s & link_prev_reg;

  // pll runs only while awake; lock counts only then
  wire locked    = pins_s.pll_locked & pins_s.sleep_n;
  wire lock_up   = locked & ~locked_prev_reg;
  wire lock_down = ~locked & locked_prev_reg;

  // port state: why the outputs are off, or that they drive
  dpoc_pkg::dpoc_port_state_t pin_state;
  dpoc_pkg::dpoc_port_state_t state_reg;
  dpoc_pkg::dpoc_port_state_t state_next;

  // what the pins alone ask for; sleep outranks lock, lock outranks enable
  assign pin_state = !pins_s.sleep_n ? dpoc_pkg::PS_SLEEP    :
                     !locked         ? dpoc_pkg::PS_UNLOCKED :
                     !pins_s.out_en  ? dpoc_pkg::PS_DISABLED :
                                       dpoc_pkg::PS_DRIVING;

  // a waking port spends one cycle in wake and one in unlocked before trusting lock;
  // this costs two cycles of drive after sleep but avoids a glitch on wake
  always_comb
  begin
    state_next = dpoc_pkg::PS_SLEEP;
    case (state_reg)
      dpoc_pkg::PS_SLEEP:
      begin
        if (pin_state == dpoc_pkg::PS_SLEEP)
          state_next = dpoc_pkg::PS_SLEEP;
        else
          state_next = dpoc_pkg::PS_WAKE;
      end
      dpoc_pkg::PS_WAKE:
      begin
        if (pin_state == dpoc_pkg::PS_SLEEP)
          state_next = dpoc_pkg::PS_SLEEP;
        else
          state_next = dpoc_pkg::PS_UNLOCKED;
      end
      dpoc_pkg::PS_UNLOCKED:
      begin
        state_next = pin_state;
      end
      dpoc_pkg::PS_DISABLED:
      begin
        state_next = pin_state;
      end
      dpoc_pkg::PS_DRIVING:
      begin
        state_next = pin_state;
      end
      default:
      begin
        state_next = dpoc_pkg::PS_SLEEP;
      end
    endcase
  end

  // port state register, asleep until the pins say otherwise
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
      state_reg <= dpoc_pkg::PS_SLEEP;
    else
      state_reg <= state_next;
  end

  // data and clock outputs drive only awake, enabled and locked
  wire drive_ok = (state_next == dpoc_pkg::PS_DRIVING);

  // 2E7 sequence, x^7 + x^6 + 1, one step per received word
  assign lfsr_next = {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};

  // backward mode passes the word untouched
  wire [23:0] derand_mask = {lfsr_reg[2:0], lfsr_reg, lfsr_reg, lfsr_reg};
  assign word_next = pins_s.rand_dis ? word_s : (word_s ^ derand_mask);

  // capture path, restarted at each new lock so both ends align
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      link_prev_reg   <= 1'b0;
      locked_prev_reg <= 1'b0;
      lfsr_reg        <= `DPOC_LFSR_SEED;
      word_reg        <= `DPOC_WORD_RESET;
    end
    else
    begin
      link_prev_reg   <= link_s;
      locked_prev_reg <= locked;
      if (lock_up)
        lfsr_reg <= `DPOC_LFSR_SEED;
      else if (link_rise && locked)
      begin
        lfsr_reg <= lfsr_next;
        word_reg <= word_next;
      end
    end
  end

  // launch taps: offset 0 on the falling link edge, then one and two cycles later
  wire [2:0] launch_tap = {launch_reg, link_fall};

  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
      launch_reg <= 2'h0;
    else
      launch_reg <= {launch_reg[0], link_fall};
  end

  // stagger mode separates groups; spread mode scatters them around the clock
  wire [5:0] group_offs = pins_s.stagger_sel ? `DPOC_OFFS_STAGGER : `DPOC_OFFS_SPREAD;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_group
      wire [1:0] off  = group_offs[2*g +: 2];
      wire       load = launch_tap[off];

      // each byte group has its own launch point and enable
      always_ff @(posedge core_clk_in)
      begin
        if (!resetn_in)
        begin
          data_reg[8*g +: 8] <= 8'h00;
          data_oe_reg[g]     <= 1'b0;
        end
        else
        begin
          if (load)
            data_reg[8*g +: 8] <= word_reg[8*g +: 8];
          data_oe_reg[g] <= drive_ok;
        end
      end
    end
  endgenerate

  // clock launched at the falling link edge, so the strobe edge is mid-word;
  // spread mode holds the clock one more cycle
  wire clk_src = pins_s.stagger_sel ? link_s : clk_dly_reg;
  wire clk_pol = clk_src ^ ~pins_s.edge_sel;

  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      clk_dly_reg <= 1'b0;
      clk_reg     <= 1'b0;
      clk_oe_reg  <= 1'b0;
      lock_reg    <= 1'b0;
      lock_oe_reg <= 1'b0;
      pll_en_reg  <= 1'b0;
    end
    else
    begin
      clk_dly_reg <= link_s;
      clk_reg     <= clk_pol;
      clk_oe_reg  <= drive_ok;
      lock_reg    <= locked;
      lock_oe_reg <= pins_s.sleep_n;
      pll_en_reg  <= pins_s.sleep_n;
    end
  end

  // register decode
  wire wr_status = reg_wr_in && (reg_addr_in == `DPOC_ADDR_STATUS);
  wire wr_mask   = reg_wr_in && (reg_addr_in == `DPOC_ADDR_MASK);

  // events: lock gained, lock lost, word captured while driving
  wire [`DPOC_EV_W-1:0] events = {link_rise & drive_ok, lock_down, lock_up};
  wire [`DPOC_EV_W-1:0] clr    = wr_status ? reg_wdata_in[`DPOC_EV_W-1:0] : '0;

  // a new event beats a write-one clear in the same cycle
  assign status_next = (status_reg & ~clr) | events;

  // port state sits above the pin levels so software sees why outputs are off
  wire [31:0] pins_word = {22'h0, state_reg, drive_ok, pins_s};

  // read selection, unmapped addresses read zero
  wire [31:0] rd_mux =
    (reg_addr_in == `DPOC_ADDR_STATUS) ? {29'h0, status_reg} :
    (reg_addr_in == `DPOC_ADDR_MASK)   ? {29'h0, mask_reg}   :
    (reg_addr_in == `DPOC_ADDR_PINS)   ? pins_word           :
    (reg_addr_in == `DPOC_ADDR_WORD)   ? {8'h00, word_reg}   : 32'h00000000;

  // register file and interrupt
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      status_reg <= '0;
      mask_reg   <= `DPOC_MASK_RESET;
      irq_reg    <= 1'b0;
      rdata_reg  <= 32'h00000000;
    end
    else
    begin
      status_reg <= status_next;
      if (wr_mask)
        mask_reg <= reg_wdata_in[`DPOC_EV_W-1:0];
      irq_reg    <= |(status_next & (wr_mask ? reg_wdata_in[`DPOC_EV_W-1:0] : mask_reg));
      rdata_reg  <= reg_rd_in ? rd_mux : 32'h00000000; // data only in the cycle after
    end
  end

  // every output straight from a flip-flop
  assign parallel_data_out    = data_reg;
  assign parallel_data_oe_out = data_oe_reg;
  assign out_clk_out          = clk_reg;
  assign out_clk_oe_out       = clk_oe_reg;
  assign lock_out             = lock_reg;
  assign lock_oe_out          = lock_oe_reg;
  assign pll_enable_out       = pll_en_reg;
  assign irq_out              = irq_reg;
  assign reg_rdata_out        = rdata_reg;

endmodule : dpoc_output_ctrl

`default_nettype wire

// [dpoc_params.svh]
// Purpose: named constants of the parallel output control block
// Assumes: 10 MHz core clock, one core cycle stands in for one unit interval
// Notes:   included by its bare name
// Overview of operation
// - output 24 data bits as three byte groups [7:0], [15:8], [23:16]
// - drive output clock; edge select high means rising strobe, low means falling
// - output enable low tri-states data and clock, lock keeps running
// - sleep input low tri-states data, clock, lock flag and stops the pll
// - stagger select high: three groups switch one to two intervals apart
// - stagger select low: data spread one to two intervals, clock spread one
// - randomizer disable low applies 2E7 derandomizing; high passes data unchanged
// - lock flag high while pll locked; unlocked tri-states data and clock
`ifndef DPOC_PARAMS_SVH
`define DPOC_PARAMS_SVH

// register map, byte addresses
`define DPOC_ADDR_STATUS    8'h00
`define DPOC_ADDR_MASK      8'h04
`define DPOC_ADDR_PINS      8'h08
`define DPOC_ADDR_WORD      8'h0c

// status bit positions
`define DPOC_EV_LOCK_UP     0
`define DPOC_EV_LOCK_DOWN   1
`define DPOC_EV_WORD        2
`define DPOC_EV_W           3

// group switch offsets in core cycles, two bits per group, group 1 lowest
`define DPOC_OFFS_STAGGER   6'h24
`define DPOC_OFFS_SPREAD    6'h21

// derandomizer seed reloaded at each lock
`define DPOC_LFSR_SEED      7'h7f

// reset values
`define DPOC_MASK_RESET     3'h0
`define DPOC_WORD_RESET     24'h000000

`endif

// [dpoc_pkg.sv]
// Purpose: types of the parallel output control block
// Assumes: nothing beyond the constants header
// Notes:   used by scoped names only
`default_nettype none

package dpoc_pkg;

  // configuration and status pins travel together
  typedef struct packed {
    logic edge_sel;
    logic out_en;
    logic sleep_n;
    logic stagger_sel;
    logic rand_dis;
    logic pll_locked;
  } dpoc_pins_t;

  typedef logic [23:0] dpoc_word_t;

  // output port condition, binary codes; wake is the cycle the pll restarts
  typedef enum logic [2:0] {
    PS_SLEEP    = 3'h0,
    PS_UNLOCKED = 3'h1,
    PS_DISABLED = 3'h2,
    PS_DRIVING  = 3'h3,
    PS_WAKE     = 3'h4
  } dpoc_port_state_t;

endpackage : dpoc_pkg

`default_nettype wire

// [dpoc_sync.sv]
// Purpose: two-stage synchroniser for a bundle of asynchronous levels
// Assumes: inputs arrive from outside the core clock domain
// Notes:   first stage is read only by the second
`default_nettype none

module dpoc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // both stages clear together; metastability settles in the first
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : dpoc_sync

`default_nettype wire

// [dpoc_chk_sva.sv]
// Purpose: pin-level checks of the output control block
// Assumes: pin changes settle within six core cycles
// Notes:   bound from the bench top
`default_nettype none

module dpoc_chk (
  input wire logic       core_clk_in,
  input wire logic       resetn_in,
  input wire logic       pll_locked_in,
  input wire logic       output_enable_in,
  input wire logic       receiver_sleep_n_in,
  input wire logic [2:0] parallel_data_oe_out,
  input wire logic       out_clk_oe_out,
  input wire logic       lock_out,
  input wire logic       lock_oe_out,
  input wire logic       pll_enable_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // full drive condition, all three pins at once
  wire logic all_on = pll_locked_in & output_enable_in & receiver_sleep_n_in;

  chk_oe_groups_same:
    assert property (parallel_data_oe_out == {3{out_clk_oe_out}}) else $error("enables differ");
  chk_sleep_pll_lock:
    assert property (lock_oe_out == pll_enable_out) else $error("lock drive and pll split");
  chk_sleep_no_lock:
    assert property (!pll_enable_out |-> !lock_out) else $error("lock high asleep");
  chk_sleep_all_off:
    assert property ((!receiver_sleep_n_in)[*6] |-> !out_clk_oe_out && !pll_enable_out)
    else $error("outputs driven asleep");
  chk_disable_off:
    assert property ((!output_enable_in)[*6] |-> !out_clk_oe_out && !parallel_data_oe_out)
    else $error("outputs driven while disabled");
  chk_unlock_off:
    assert property ((!pll_locked_in)[*6] |-> !out_clk_oe_out && !lock_out)
    else $error("outputs driven unlocked");
  chk_all_on_drive:
    assert property (all_on[*6] |-> out_clk_oe_out && (&parallel_data_oe_out))
    else $error("outputs idle when enabled");
  chk_lock_flag_high:
    assert property ((pll_locked_in & receiver_sleep_n_in)[*6] |-> lock_out)
    else $error("lock flag low");
  chk_enable_keeps_lock:
    assert property ((pll_locked_in & receiver_sleep_n_in & !output_enable_in)[*6]
      |-> lock_out && pll_enable_out) else $error("lock lost on disable");
  cov_drive: cover property (out_clk_oe_out);
  cov_sleep: cover property ($fell(pll_enable_out));
  cov_unlock: cover property ($fell(lock_out));
endmodule : dpoc_chk

`default_nettype wire

// [dpoc_link_src.sv]
// Purpose: recovered link source feeding the block
// Assumes: 800 ns link period, word stable around the rising edge
// Notes:   clock stands low between frames
`default_nettype none

module dpoc_link_src (
  input  wire logic        run_in,
  input  wire logic [23:0] word_in,
  output logic             link_clk_out,
  output logic      [23:0] rx_word_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // odd offset keeps link edges off the core edges
  initial
  begin
    link_clk_out = 1'b0;
    rx_word_out = 24'h000000;
    forever
    begin
      wait (run_in);
      #37;
      while (run_in)
      begin
        rx_word_out = word_in;
        #200 link_clk_out = 1'b1;
        #400 link_clk_out = 1'b0;
        #200;
      end
      rx_word_out = ~rx_word_out; // stale word must not look valid
    end
  end
endmodule : dpoc_link_src

`default_nettype wire

// [tb_dpoc.sv]
// Purpose: self-checking bench of the output control block
// Assumes: one core cycle per unit interval, 8 cycles a link period
// Notes:   pins driven by non-blocking assignment, at the rising edge or, for configuration pins, 1 ns after it
`include "dpoc_params.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, run = 0, edge_sel = 1, out_en = 1, sleep_n = 1, stag = 1;
  logic rand_dis = 0, locked = 0, wr = 0, rd = 0, lclk, irq, oclk, oclk_oe, lock_o, lock_oe;
  logic pll_en, ck_hi, ck_lo;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, got;
  logic [23:0] word = 24'h5a3c96, rx, dout;
  logic [2:0]  doe;
  int mismatches = 0, n_tests = 0;
  always #50 clk = ~clk;
  dpoc_link_src u_src (.run_in(run), .word_in(word), .link_clk_out(lclk), .rx_word_out(rx));
  dpoc_output_ctrl u_dut (.core_clk_in(clk), .resetn_in(rst_n), .link_clk_in(lclk),
    .rx_word_in(rx), .pll_locked_in(locked), .output_edge_select_in(edge_sel),
    .output_enable_in(out_en), .receiver_sleep_n_in(sleep_n),
    .staggered_turnon_select_in(stag), .randomizer_disable_in(rand_dis),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .irq_out(irq), .parallel_data_out(dout),
    .parallel_data_oe_out(doe), .out_clk_out(oclk), .out_clk_oe_out(oclk_oe),
    .lock_out(lock_o), .lock_oe_out(lock_oe), .pll_enable_out(pll_en));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a; rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 got = rdata; // data stands only in this cycle
  endtask : rd_reg
  // flip every byte, then time each group's switch against group 1
  task automatic t_groups(input logic mode, input int d2, input int d3, output logic ck);
    int t[3];
    logic [23:0] prev;
    stag <= mode;
    cyc(24);
    prev = dout;
    t = '{-1, -1, -1};
    word <= ~word;
    for (int n = 0; n < 40; n++)
    begin
      cyc(1);
      for (int g = 0; g < 3; g++)
        if (t[g] < 0 && dout[g*8+:8] !== prev[g*8+:8]) t[g] = n;
      if (t[0] == n) ck = oclk;
    end
    check(t[1] - t[0], d2);
    check(t[2] - t[0], d3);
    check(dout, word);
  endtask : t_groups
  task conclude();
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    #500000;
    mismatches++;
    conclude();
  end
  initial
  begin
    cyc(19);
    check(doe, 3'h0);
    @(posedge clk) rst_n <= 1;
    wr_reg(`DPOC_ADDR_MASK, 32'h1); // interrupt on lock gain
    @(posedge clk) begin locked <= 1; run <= 1; end
    wait (dout !== 24'h000000 || $time > 20000);
    cyc(4);
    check(dout, 24'ha5c369);
    check(irq, 1'b1);
    rand_dis <= 1;
    cyc(20);
    check({doe, oclk_oe, lock_o, lock_oe, pll_en}, 7'h7f);
    t_groups(1'b1, 1, 2, ck_hi);
    edge_sel <= 0;
    t_groups(1'b1, 1, 2, ck_lo);
    check(ck_lo, !ck_hi);
    t_groups(1'b0, -1, 1, ck_lo);
    out_en <= 0;
    cyc(8);
    check({doe, oclk_oe, lock_o, pll_en}, 6'h03);
    out_en <= 1;
    sleep_n <= 0;
    cyc(8);
    check({doe, oclk_oe, lock_o, lock_oe, pll_en}, 7'h00);
    sleep_n <= 1;
    wr_reg(`DPOC_ADDR_MASK, 32'h2); // now only lock loss interrupts
    wr_reg(`DPOC_ADDR_STATUS, 32'h7);
    locked <= 0;
    cyc(8);
    check({doe, oclk_oe, lock_o}, 5'h00);
    check(irq, 1'b1);
    rd_reg(`DPOC_ADDR_STATUS);
    check(got[1], 1'b1);
    wr_reg(`DPOC_ADDR_STATUS, 32'h7);
    cyc(2);
    check(irq, 1'b0);
    rd_reg(8'h10);
    check(got, 32'h0);
    rd_reg(`DPOC_ADDR_PINS);
    check(got, 32'h9a); // awake, enabled, randomizer off, state unlocked
    rd_reg(`DPOC_ADDR_WORD);
    check(got, {8'h00, word});
    conclude();
  end
endmodule : tb

bind dpoc_output_ctrl dpoc_chk u_chk (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .pll_locked_in(pll_locked_in), .output_enable_in(output_enable_in),
  .receiver_sleep_n_in(receiver_sleep_n_in), .parallel_data_oe_out(parallel_data_oe_out),
  .out_clk_oe_out(out_clk_oe_out), .lock_out(lock_out), .lock_oe_out(lock_oe_out),
  .pll_enable_out(pll_enable_out));

`default_nettype wire
